//--- core/area_decoder_regs.vh
// Register offsets, field positions, reset values and address decode constants
`ifndef AREA_DECODER_REGS_VH
`define AREA_DECODER_REGS_VH
// Offsets are register indices; the bus byte address is four times the index
`define OFS_BUS_CONTROL_ONE 32'hFFFFFF60
`define OFS_BUS_CONTROL_TWO 32'hFFFFFF62
`define OFS_WAIT_CONTROL_ONE 32'hFFFFFF64
`define OFS_WAIT_CONTROL_TWO 32'hFFFFFF66
`define OFS_PER_AREA_MEMORY_CONTROL 32'h0FFFFF68
`define OFS_REFRESH_TIMER_CTRL_STATUS 32'h0FFFFF6E
`define OFS_REFRESH_COUNTER_VALUE 32'hFFFFFF70
`define OFS_REFRESH_COMPARE_CONSTANT 32'hFFFFFF72
`define OFS_REFRESH_EVENT_COUNT 32'hFFFFFF74
`define OFS_AREA_SETUP 32'hFFFFFF80
`define OFS_DECODE_STATUS 32'hFFFFFF84
// Mode window indices FFFFD000 upward, seen on byte address bits 31:14
`define SDRAM_MODE_SET_AREA2_WINDOW_BASE 18'h3FFFD
// Enabled edges the strap waits for the synchroniser to fill
`define STRAP_SETTLE 2'h2
`define RST_BUS_CONTROL_ONE 16'h0000
`define RST_BUS_CONTROL_TWO 16'h3FF0
`define RST_WAIT_CONTROL_ONE 16'h3FF3
`define RST_WAIT_CONTROL_TWO 16'hFFFF
`define RST_ZERO16 16'h0000
`define RST_AREA_SETUP 8'h00
`define AREA_MSB 28
`define AREA_LSB 26
`define WIDTH_RESERVED 2'h0
`define WIDTH_8 2'h1
`define WIDTH_16 2'h2
`define WIDTH_32 2'h3
`define BUS_CONTROL_TWO_A2_LSB 4
`endif

//--- core/area_select_decode.v
// Combinational area decode of a physical address
`timescale 1ns/1ps
`include "area_decoder_regs.vh"
module area_select_decode (
	input wire [31:0] addr,
	output wire [2:0] area,
	output wire [6:0] area_hot
);
	// Only bits 28:26 matter; upper bits are the cache method and alias away
	assign area = addr[`AREA_MSB:`AREA_LSB];
	genvar g;
	generate
		for (g = 0; g < 7; g = g + 1) begin : g_hot
			assign area_hot[g] = (area == g[2:0]);
		end
	endgenerate
endmodule // area_select_decode

//--- core/area_width_select.v
// Bus width choice for one area
`timescale 1ns/1ps
`include "area_decoder_regs.vh"
module area_width_select (
	input wire [2:0] area,
	input wire [1:0] boot_width,
	input wire [15:0] bus_two,
	input wire [7:0] sdram_en,
	output reg [1:0] width,
	output reg width_bad
);
	reg [1:0] fld;
	// Area 0 from strap, 2..6 from two-bit fields of bus control two
	always @* begin
		fld = `WIDTH_RESERVED;
		width = `WIDTH_RESERVED;
		width_bad = 1'b0;
		case (area)
		3'h0: width = boot_width;
		3'h2, 3'h3, 3'h4, 3'h5, 3'h6: begin
			fld = bus_two[(`BUS_CONTROL_TWO_A2_LSB + 2 * (area - 3'h2)) +: 2];
			width = fld;
			// SDRAM cannot run eight bits; flag it, do not silently widen
			if (sdram_en[area] && fld == `WIDTH_8)
				width_bad = 1'b1;
		end
		default: width = `WIDTH_RESERVED;
		endcase
		if (width == `WIDTH_RESERVED && (area == 3'h0 || area >= 3'h2) && area != 3'h7)
			width_bad = 1'b1;
	end
endmodule // area_width_select

//--- core/external_bus_controller.v
// Area decoder, chip selects and register file of the external bus controller
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "area_decoder_regs.vh"
module external_bus_controller (
	input wire clock,
	input wire nrst,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire cpu_valid,
	input wire [31:0] cpu_addr,
	input wire cpu_write,
	input wire [7:0] cpu_wdata,
	input wire boot_width_pin_hi,
	input wire boot_width_pin_lo,
	output reg area0_select_n,
	output reg area2_select_n,
	output reg area3_select_n,
	output reg area4_select_n,
	output reg area5_select_n,
	output reg area6_select_n,
	output reg [1:0] access_width,
	output reg access_width_bad,
	output reg sdram_mode_strobe,
	output reg [11:0] sdram_mode_addr,
	output reg [7:0] sdram_mode_data
);
	reg [15:0] bus_one_q;
	reg [15:0] bus_two_q;
	reg [15:0] wait_one_q;
	reg [15:0] wait_two_q;
	reg [15:0] mem_ctrl_q;
	reg [15:0] rt_status_q;
	reg [15:0] rt_count_q;
	reg [15:0] rt_compare_q;
	reg [15:0] rf_count_q;
	reg [7:0] sdram_en_q;
	reg [1:0] boot_width_q;
	reg [1:0] pin_s1_q;
	reg [1:0] pin_s2_q;
	reg strap_taken_q;
	reg [1:0] strap_wait_q;
	reg [2:0] last_area_q;
	reg [31:0] rdata_d;
	reg hit_d;
	wire [2:0] cur_area;
	wire [6:0] cur_hot;
	wire [1:0] cur_width;
	wire cur_bad;
	wire apb_setup;
	wire apb_wr;
	wire sdram_mode_set_area2_hit;

	// Byte address against index times four; index bits 31:30 fall off the bus
	function [0:0] is_addr;
		input [31:0] a;
		input [31:0] b;
		begin
			is_addr = (a == {b[29:0], 2'h0});
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	area_select_decode u_decode (
		.addr(cpu_addr),
		.area(cur_area),
		.area_hot(cur_hot)
	);

	area_width_select u_width (
		.area(cur_area),
		.boot_width(boot_width_q),
		.bus_two(bus_two_q),
		.sdram_en(sdram_en_q),
		.width(cur_width),
		.width_bad(cur_bad)
	);

	////////////////////////////////////////////////////////////////////////
	// Mode pins come from outside, so two flops before anything reads them
	always @(posedge clock) begin
		if (!nrst) begin
			pin_s1_q <= 2'h0;
			pin_s2_q <= 2'h0;
		end else if (clk_en) begin
			pin_s1_q <= {boot_width_pin_hi, boot_width_pin_lo};
			pin_s2_q <= pin_s1_q;
		end
	end

	// Strap waits until the sync flops hold the pins, else it would catch their reset zero
	always @(posedge clock) begin
		if (!nrst) begin
			strap_taken_q <= 1'b0;
			strap_wait_q <= 2'h0;
			boot_width_q <= `WIDTH_RESERVED;
		end else if (clk_en && !strap_taken_q) begin
			if (strap_wait_q == `STRAP_SETTLE) begin
				strap_taken_q <= 1'b1; // Caught once, later pin changes ignored
				boot_width_q <= pin_s2_q;
			end else begin
				strap_wait_q <= strap_wait_q + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pwrite && pready;
	// Any index in the 16 KB window counts; the index offset goes to the SDRAM
	assign sdram_mode_set_area2_hit = (paddr[31:14] == `SDRAM_MODE_SET_AREA2_WINDOW_BASE);

	always @* begin
		hit_d = 1'b1;
		rdata_d = 32'h00000000;
		if (is_addr(paddr, `OFS_BUS_CONTROL_ONE))
			rdata_d = {16'h0000, bus_one_q};
		else if (is_addr(paddr, `OFS_BUS_CONTROL_TWO))
			rdata_d = {16'h0000, bus_two_q};
		else if (is_addr(paddr, `OFS_WAIT_CONTROL_ONE))
			rdata_d = {16'h0000, wait_one_q};
		else if (is_addr(paddr, `OFS_WAIT_CONTROL_TWO))
			rdata_d = {16'h0000, wait_two_q};
		else if (is_addr(paddr, `OFS_PER_AREA_MEMORY_CONTROL))
			rdata_d = {16'h0000, mem_ctrl_q};
		else if (is_addr(paddr, `OFS_REFRESH_TIMER_CTRL_STATUS))
			rdata_d = {16'h0000, rt_status_q};
		else if (is_addr(paddr, `OFS_REFRESH_COUNTER_VALUE))
			rdata_d = {16'h0000, rt_count_q};
		else if (is_addr(paddr, `OFS_REFRESH_COMPARE_CONSTANT))
			rdata_d = {16'h0000, rt_compare_q};
		else if (is_addr(paddr, `OFS_REFRESH_EVENT_COUNT))
			rdata_d = {16'h0000, rf_count_q};
		else if (is_addr(paddr, `OFS_AREA_SETUP))
			rdata_d = {24'h000000, sdram_en_q};
		else if (is_addr(paddr, `OFS_DECODE_STATUS))
			rdata_d = {24'h000000, strap_taken_q, boot_width_q, 2'h0, last_area_q};
		else if (sdram_mode_set_area2_hit)
			rdata_d = 32'h00000000; // Write only, reads return zero
		else
			hit_d = 1'b0;
	end

	// No wait states: pready rises in the first access cycle
	always @(posedge clock) begin
		if (!nrst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (clk_en) begin
			pready <= apb_setup;
			pslverr <= apb_setup && !hit_d;
			prdata <= (apb_setup && !pwrite) ? rdata_d : 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register writes; every register has its initial value on reset
	always @(posedge clock) begin
		if (!nrst) begin
			bus_one_q <= `RST_BUS_CONTROL_ONE;
			bus_two_q <= `RST_BUS_CONTROL_TWO;
			wait_one_q <= `RST_WAIT_CONTROL_ONE;
			wait_two_q <= `RST_WAIT_CONTROL_TWO;
			mem_ctrl_q <= `RST_ZERO16;
			rt_status_q <= `RST_ZERO16;
			rt_count_q <= `RST_ZERO16;
			rt_compare_q <= `RST_ZERO16;
			rf_count_q <= `RST_ZERO16;
			sdram_en_q <= `RST_AREA_SETUP;
		end else if (clk_en && apb_wr) begin
			if (is_addr(paddr, `OFS_BUS_CONTROL_ONE))
				bus_one_q <= pwdata[15:0];
			if (is_addr(paddr, `OFS_BUS_CONTROL_TWO))
				bus_two_q <= pwdata[15:0];
			if (is_addr(paddr, `OFS_WAIT_CONTROL_ONE))
				wait_one_q <= pwdata[15:0];
			if (is_addr(paddr, `OFS_WAIT_CONTROL_TWO))
				wait_two_q <= pwdata[15:0];
			if (is_addr(paddr, `OFS_PER_AREA_MEMORY_CONTROL))
				mem_ctrl_q <= pwdata[15:0];
			if (is_addr(paddr, `OFS_REFRESH_TIMER_CTRL_STATUS))
				rt_status_q <= pwdata[15:0];
			if (is_addr(paddr, `OFS_REFRESH_COUNTER_VALUE))
				rt_count_q <= pwdata[15:0];
			if (is_addr(paddr, `OFS_REFRESH_COMPARE_CONSTANT))
				rt_compare_q <= pwdata[15:0];
			if (is_addr(paddr, `OFS_REFRESH_EVENT_COUNT))
				rf_count_q <= pwdata[15:0];
			// Only areas 2 and 3 can carry SDRAM
			if (is_addr(paddr, `OFS_AREA_SETUP))
				sdram_en_q <= {4'h0, pwdata[3:2], 2'h0};
		end
	end

	// Mode-set write forwarded as a one-cycle strobe with window offset
	always @(posedge clock) begin
		if (!nrst) begin
			sdram_mode_strobe <= 1'b0;
			sdram_mode_addr <= 12'h000;
			sdram_mode_data <= 8'h00;
		end else if (clk_en) begin
			sdram_mode_strobe <= apb_wr && sdram_mode_set_area2_hit;
			if (apb_wr && sdram_mode_set_area2_hit) begin
				sdram_mode_addr <= paddr[13:2];
				sdram_mode_data <= pwdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Chip selects registered; area 1 and 7 leave all deasserted
	always @(posedge clock) begin
		if (!nrst) begin
			area0_select_n <= 1'b1;
			area2_select_n <= 1'b1;
			area3_select_n <= 1'b1;
			area4_select_n <= 1'b1;
			area5_select_n <= 1'b1;
			area6_select_n <= 1'b1;
			access_width <= `WIDTH_RESERVED;
			access_width_bad <= 1'b0;
			last_area_q <= 3'h0;
		end else if (clk_en) begin
			area0_select_n <= !(cpu_valid && cur_hot[0]);
			area2_select_n <= !(cpu_valid && cur_hot[2]);
			area3_select_n <= !(cpu_valid && cur_hot[3]);
			area4_select_n <= !(cpu_valid && cur_hot[4]);
			area5_select_n <= !(cpu_valid && cur_hot[5]);
			area6_select_n <= !(cpu_valid && cur_hot[6]);
			access_width <= cpu_valid ? cur_width : `WIDTH_RESERVED;
			access_width_bad <= cpu_valid && cur_bad;
			if (cpu_valid)
				last_area_q <= cur_area;
		end
	end
endmodule // external_bus_controller

//--- sim/area_decoder_props.sv
// Checker for area decode, chip selects and the mode window
`timescale 1ns/1ps
module area_decoder_props (
	input wire clock,
	input wire nrst,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire cpu_valid,
	input wire [31:0] cpu_addr,
	input wire area0_select_n,
	input wire area2_select_n,
	input wire area3_select_n,
	input wire area4_select_n,
	input wire area5_select_n,
	input wire area6_select_n,
	input wire sdram_mode_strobe,
	input wire [11:0] sdram_mode_addr,
	input wire [7:0] sdram_mode_data
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// Upper three bits never reach the decode
	wire [2:0] ar = cpu_addr[28:26];
	wire win = paddr[31:14] == 18'h3FFFD;
	wire [5:0] sel = {area6_select_n, area5_select_n, area4_select_n,
		area3_select_n, area2_select_n, area0_select_n};
	property p_sel0;
		$past(nrst && clk_en) |-> area0_select_n == !($past(cpu_valid) && $past(ar) == 3'h0);
	endproperty
	a_sel0: assert property (p_sel0) else $error("area 0 select wrong");
	property p_sel2;
		$past(nrst && clk_en) |-> area2_select_n == !($past(cpu_valid) && $past(ar) == 3'h2);
	endproperty
	a_sel2: assert property (p_sel2) else $error("area 2 select wrong");
	property p_sel5;
		$past(nrst && clk_en) |-> area5_select_n == !($past(cpu_valid) && $past(ar) == 3'h5);
	endproperty
	a_sel5: assert property (p_sel5) else $error("area 5 select wrong");
	property p_none;
		$past(nrst && clk_en) && $past(cpu_valid) && ($past(ar) == 3'h1 || $past(ar) == 3'h7)
			|-> &sel;
	endproperty
	a_none: assert property (p_none) else $error("select in area 1 or 7");
	property p_one;
		$onehot0(~sel);
	endproperty
	a_one: assert property (p_one) else $error("two selects low");
	property p_strobe;
		psel && penable && pwrite && pready && win |=> sdram_mode_strobe
			&& sdram_mode_addr == $past(paddr[13:2]) && sdram_mode_data == $past(pwdata[7:0]);
	endproperty
	a_strobe: assert property (p_strobe) else $error("mode write not forwarded");
	property p_src;
		sdram_mode_strobe |-> $past(psel && penable && pwrite && pready && win);
	endproperty
	a_src: assert property (p_src) else $error("stray mode strobe");
	property p_wrd;
		psel && penable && !pwrite && win |-> pready && prdata == 32'h0 && !pslverr;
	endproperty
	a_wrd: assert property (p_wrd) else $error("mode window read wrong");
	property p_hold;
		$past(nrst) && !sdram_mode_strobe |-> $stable(sdram_mode_addr);
	endproperty
	a_hold: assert property (p_hold) else $error("mode address moved");
	c_sel2: cover property (!area2_select_n);
	c_strobe: cover property (sdram_mode_strobe);
	c_err: cover property (pready && pslverr);
endmodule // area_decoder_props
bind external_bus_controller area_decoder_props area_decoder_props_i (.*);

//--- sim/sdram_mode_model.sv
// Far-side memory keeping the last mode word it was given
`timescale 1ns/1ps
module sdram_mode_model (
	input wire clock,
	input wire nrst,
	input wire strobe,
	input wire [11:0] maddr,
	input wire [7:0] mdata,
	output reg [19:0] mode_q
);
	// Mode register only changes on a strobe, like a real device
	always @(posedge clock) begin
		if (!nrst)
			mode_q <= 20'h00000;
		else if (strobe)
			mode_q <= {maddr, mdata};
	end
endmodule // sdram_mode_model

//--- sim/external_bus_controller_tb_top.sv
// Self-checking bench for the external bus controller
`timescale 1ns/1ps
module external_bus_controller_tb_top;
	logic clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, cpu_valid = 0;
	logic cpu_write = 0, pin_hi = 0, pin_lo = 0, pready, pslverr, err, wbad, strobe;
	logic ce = 1;
	logic s0, s2, s3, s4, s5, s6;
	logic [31:0] paddr = 0, pwdata = 0, cpu_addr = 0, prdata, rd, a;
	logic [7:0] cpu_wdata = 0, mdata;
	logic [1:0] width, sdr;
	logic [11:0] maddr;
	logic [19:0] mode;
	logic [15:0] bus_control_two;
	logic [31:0] ra [9] = '{32'hFFFFFF60, 32'hFFFFFF62, 32'hFFFFFF64, 32'hFFFFFF66,
		32'h0FFFFF68, 32'h0FFFFF6E, 32'hFFFFFF70, 32'hFFFFFF72, 32'hFFFFFF74};
	logic [15:0] rv [9] = '{16'h0000, 16'h3FF0, 16'h3FF3, 16'hFFFF, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000};
	integer fails = 0, comparisons = 0, s, i;
	always #4 clock = ~clock;
	external_bus_controller external_bus_controller_i (.clock(clock), .nrst(nrst),
		.clk_en(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_valid(cpu_valid), .cpu_addr(cpu_addr), .cpu_write(cpu_write),
		.cpu_wdata(cpu_wdata), .boot_width_pin_hi(pin_hi), .boot_width_pin_lo(pin_lo),
		.area0_select_n(s0), .area2_select_n(s2), .area3_select_n(s3),
		.area4_select_n(s4), .area5_select_n(s5), .area6_select_n(s6),
		.access_width(width), .access_width_bad(wbad), .sdram_mode_strobe(strobe),
		.sdram_mode_addr(maddr), .sdram_mode_data(mdata));
	sdram_mode_model sdram_mode_model_i (.clock(clock), .nrst(nrst), .strobe(strobe),
		.maddr(maddr), .mdata(mdata), .mode_q(mode));
	////////////////////////////////////////////////////////////////////////////////
	task summarize;
		$display("checks %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One APB transfer; the wait is bounded so a dead slave ends the run
	task apb(input logic w, input logic [31:0] ad, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		integer n;
		begin
			@(posedge clock);
			psel <= 1;
			penable <= 0;
			pwrite <= w;
			paddr <= ad;
			pwdata <= d;
			@(posedge clock);
			penable <= 1;
			n = 0;
			do begin
				@(posedge clock);
				n = n + 1;
			end while (pready !== 1'b1 && n < 16);
			if (n >= 16) begin
				fails = fails + 1;
				summarize;
			end
			r = prdata;
			e = pslverr;
			psel <= 0;
			penable <= 0;
		end
	endtask
	// Model of decode and width, compared one cycle after the access
	task cpu(input logic [31:0] ad);
		logic [2:0] ar;
		logic [1:0] w;
		logic [6:0] es;
		begin
			ar = ad[28:26];
			es = 7'h7F;
			if (ar != 3'h1 && ar != 3'h7)
				es[ar] = 1'b0;
			w = (ar == 3'h0) ? s : bus_control_two >> (4 + 2 * (ar - 2));
			@(posedge clock);
			cpu_valid <= 1;
			cpu_addr <= ad;
			cpu_write <= $urandom;
			cpu_wdata <= $urandom;
			@(posedge clock);
			#1;
			check("select", {s6, s5, s4, s3, s2, s0}, {es[6:2], es[0]});
			if (ar != 3'h1) begin
				check("width", width, w);
				check("bad", wbad, w == 0 || (w == 1 && (ar == 2 && sdr[0] || ar == 3 && sdr[1])));
			end
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Each strap code needs its own reset, the pins are taken once only
	initial begin
		i = $urandom(34285);
		for (s = 0; s < 4; s = s + 1) begin
			@(posedge clock);
			nrst <= 0;
			{pin_hi, pin_lo} <= s[1:0];
			repeat (8) @(posedge clock);
			nrst <= 1;
			repeat (5) @(posedge clock);
			// Bus control one is written first, before any access outside area 0
			// Shared ports stay unused here, so 32-bit widths remain legal
			for (i = 0; i < 9; i = i + 1) begin
				apb(0, {ra[i][29:0], 2'h0}, 0, rd, err);
				check("reset", rd, rv[i]);
				a = $urandom;
				apb(1, {ra[i][29:0], 2'h0}, a, rd, err);
				apb(0, {ra[i][29:0], 2'h0}, 0, rd, err);
				check("readback", rd, a[15:0]);
				if (i == 1)
					bus_control_two = a[15:0];
			end
			a = $urandom;
			sdr = a[3:2];
			apb(1, 32'hFFFFFE00, a & 32'h0000000C, rd, err); // Area setup, index FFFFFF80
			for (i = 0; i < 30; i = i + 1) begin
				a = $urandom;
				if (a[28:26] == 3'h7)
					a[28:26] = 3'h1;
				cpu(a);
			end
			a = $urandom;
			apb(1, {18'h3FFFD, a[11:0], 2'h0}, a, rd, err);
			repeat (2) @(posedge clock);
			#1;
			check("mode", mode, {a[11:0], a[7:0]});
			apb(0, {18'h3FFFD, a[11:0], 2'h0}, 0, rd, err);
			check("mode read", rd, 32'h00000000);
			check("mode read err", err, 32'h00000000);
			apb(0, 32'hFFFFFF90, 0, rd, err);
			check("unmapped", err, 1);
			// Enable low: a new area on the address must not move the selects
			ce <= 0;
			cpu_addr <= {cpu_addr[31:29], ~cpu_addr[28], 2'h0, cpu_addr[25:0]};
			#1;
			rd = {26'h0000000, s6, s5, s4, s3, s2, s0};
			repeat (3) @(posedge clock);
			#1;
			check("freeze", {s6, s5, s4, s3, s2, s0}, rd);
			@(posedge clock);
			ce <= 1;
		end
		summarize;
	end
endmodule // external_bus_controller_tb_top
